// ---- dpc_pkg.sv ----
// package: constants and carriers for deflection mode pin control
package dpc_pkg;
    // timing: core clock period and line-rate thresholds (periods in ns)
    localparam int unsigned CLK_NS        = 10;
    localparam int unsigned HPER_35K_NS   = 28571;   // 35 kHz line period
    localparam int unsigned HPER_38K_NS   = 26316;   // 38 kHz line period
    localparam int unsigned HPER_31K_NS   = 32000;   // 31.25 kHz line period
    localparam int unsigned HPER_19K_NS   = 52632;   // 19 kHz line period
    // longest period still counted as the range: round down
    localparam logic [15:0] CYC_35K = 16'(HPER_35K_NS / CLK_NS);
    localparam logic [15:0] CYC_38K = 16'(HPER_38K_NS / CLK_NS);
    localparam logic [15:0] CYC_31K = 16'(HPER_31K_NS / CLK_NS);
    localparam logic [15:0] CYC_MAX = 16'hFFFF;
    localparam logic [15:0] CYC_ZERO = 16'h0000;
    // lines per field accepted
    localparam logic [9:0]  LINES_MIN = 10'd192;
    localparam logic [9:0]  LINES_MAX = 10'd680;
    localparam logic [9:0]  LINES_ZERO = 10'h000;
    // pwm line phase counter
    localparam logic [7:0]  PWM_ZERO = 8'h00;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        DPC_RANGE_31K,
        DPC_RANGE_35K,
        DPC_RANGE_38K
    } dpc_range_e;

    // host settings written over the serial control bus
    typedef struct packed {
        logic       switch_ctrl_bit;
        logic [7:0] dac_level;
        logic       pwm_parabola;
        logic [7:0] pwm_width;
        logic       softstart_en;
    } dpc_cfg_s;

    // detected frequency flags
    typedef struct packed {
        logic freq_flag_mid;
        logic freq_flag_high;
    } dpc_flags_s;
endpackage

// ---- dpc_pin_ctrl.sv ----
// module: pin-level mode, frequency flag, protection and switch control
module dpc_pin_ctrl (
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    // mode pins
    input  wire logic              clock_source_select_i,
    input  wire logic              test_select_i,
    input  wire logic              line_rate_select_i,
    input  wire logic              monitor_mode_i,
    // sync and watch inputs
    input  wire logic              hsync_i,
    input  wire logic              vsync_i,
    input  wire logic              supply_watch_in_i,
    input  wire logic              hprot_trip_i,
    input  wire logic              vprot_trip_i,
    input  wire logic              softstart_disable_in_i,
    // host settings
    input  wire logic              cfg_we_i,
    input  wire dpc_pkg::dpc_cfg_s cfg_i,
    // outputs
    output logic                   ext_clock_sel_o,
    output logic                   test_mode_o,
    output logic                   double_rate_o,
    output dpc_pkg::dpc_flags_s    flags_o,
    output dpc_pkg::dpc_range_e    pll_range_o,
    output logic                   protection_active_out_o,
    output logic                   softstart_active_o,
    output logic                   switch_out_o,
    output logic [7:0]             dac_level_o,
    output logic                   pwm_o,
    output logic                   field_ok_o
);
    // ----------------------------------------------------------------
    // input synchronisers: every pin passes two flops
    // ----------------------------------------------------------------
    localparam int NPIN = 10;
    logic [NPIN-1:0] pin_raw, s1_reg, s2_reg, s1_next, s2_next;
    assign pin_raw = {clock_source_select_i, test_select_i, line_rate_select_i,
                      monitor_mode_i, hsync_i, vsync_i, supply_watch_in_i,
                      hprot_trip_i, vprot_trip_i, softstart_disable_in_i};
    always_comb begin
        s1_next = pin_raw;
        s2_next = s1_reg;
    end
    always_ff @(posedge core_clk_i) begin
        s1_reg <= s1_next;
        s2_reg <= s2_next;
    end
    logic clk_sel, tst, rate, mon, hs, vs, sup, hp, vp, ss_dis;
    assign {clk_sel, tst, rate, mon, hs, vs, sup, hp, vp, ss_dis} = s2_reg;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic                hs_d_reg, hs_d_next, vs_d_reg, vs_d_next;
    logic [15:0]         per_reg, per_next, cnt_reg, cnt_next;
    dpc_pkg::dpc_flags_s flg_reg, flg_next;
    dpc_pkg::dpc_range_e rng_reg, rng_next;
    logic                prot_reg, prot_next;
    dpc_pkg::dpc_cfg_s   cfg_reg, cfg_next;
    logic [9:0]          lines_reg, lines_next;
    logic                fok_reg, fok_next;
    logic [7:0]          ph_reg, ph_next, par_reg, par_next;
    logic                pwm_reg, pwm_next, ss_reg, ss_next;
    logic                hs_rise, vs_rise;

    assign hs_rise = hs & ~hs_d_reg;   // line sync is the timing reference
    assign vs_rise = vs & ~vs_d_reg;

    // classify a measured line period into a range
    function automatic dpc_pkg::dpc_range_e classify(input logic [15:0] per);
        if (per <= dpc_pkg::CYC_38K)
            classify = dpc_pkg::DPC_RANGE_38K;
        else if (per <= dpc_pkg::CYC_35K)
            classify = dpc_pkg::DPC_RANGE_35K;
        else
            classify = dpc_pkg::DPC_RANGE_31K;
    endfunction

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        dpc_pkg::dpc_range_e det;
        det        = classify(per_reg);
        hs_d_next  = hs;
        vs_d_next  = vs;
        cnt_next   = cnt_reg;
        per_next   = per_reg;
        flg_next   = flg_reg;
        rng_next   = rng_reg;
        prot_next  = prot_reg;
        cfg_next   = cfg_reg;
        lines_next = lines_reg;
        fok_next   = fok_reg;
        ph_next    = ph_reg;
        par_next   = par_reg;
        pwm_next   = pwm_reg;
        ss_next    = ss_reg;
        // line period measurement, saturating so a lost sync reads slow
        if (hs_rise) begin
            per_next = cnt_reg;
            cnt_next = dpc_pkg::CYC_ZERO;
        end else if (cnt_reg != dpc_pkg::CYC_MAX) begin
            cnt_next = cnt_reg + 16'h0001;
        end
        // flags only mean something in the double line-rate range
        if (rate) begin
            flg_next.freq_flag_mid  = (det != dpc_pkg::DPC_RANGE_31K);
            flg_next.freq_flag_high = (det == dpc_pkg::DPC_RANGE_38K);
        end else begin
            flg_next = '0;
        end
        // automatic range: rise at once, fall only once supply watch drops
        if (mon && rate) begin
            if (det > rng_reg)
                rng_next = det;
            else if (det < rng_reg && !sup)
                rng_next = det;
        end else begin
            rng_next = dpc_pkg::DPC_RANGE_31K;
        end
        // protection is sticky until reset
        if (hp || vp)
            prot_next = 1'b1;
        if (cfg_we_i)
            cfg_next = cfg_i;
        // lines per field check
        if (vs_rise) begin
            fok_next   = (lines_reg >= dpc_pkg::LINES_MIN) &&
                         (lines_reg <= dpc_pkg::LINES_MAX);
            // a line sync that lands with the field sync opens the new field,
            // otherwise every field would read one line short
            lines_next = hs_rise ? dpc_pkg::LINES_ZERO + 10'h001 : dpc_pkg::LINES_ZERO;
            par_next   = dpc_pkg::BYTE_ZERO;
        end else if (hs_rise && lines_reg != 10'h3FF) begin
            lines_next = lines_reg + 10'h001;
            par_next   = lines_reg[9:2];   // coarse vertical ramp for parabola
        end
        // line-rate pwm: constant width or parabola-shaped width
        if (hs_rise)
            ph_next = dpc_pkg::PWM_ZERO;
        else
            ph_next = ph_reg + 8'h01;
        if (cfg_reg.pwm_parabola)
            pwm_next = ph_reg < 8'(({8'h00, par_reg} * {8'h00, ~par_reg}) >> 6);
        else
            pwm_next = ph_reg < cfg_reg.pwm_width;
        // softstart runs until first valid line period or disabled
        if (ss_dis || !cfg_reg.softstart_en)
            ss_next = 1'b0;
        else if (hs_rise && per_reg != dpc_pkg::CYC_ZERO)
            ss_next = 1'b0;
    end

    // ----------------------------------------------------------------
    // registers, synchronous active-low reset
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            hs_d_reg  <= 1'b0;
            vs_d_reg  <= 1'b0;
            cnt_reg   <= dpc_pkg::CYC_ZERO;
            per_reg   <= dpc_pkg::CYC_ZERO;
            flg_reg   <= '0;
            rng_reg   <= dpc_pkg::DPC_RANGE_31K;
            prot_reg  <= 1'b0;
            cfg_reg   <= '0;
            lines_reg <= dpc_pkg::LINES_ZERO;
            fok_reg   <= 1'b0;
            ph_reg    <= dpc_pkg::PWM_ZERO;
            par_reg   <= dpc_pkg::BYTE_ZERO;
            pwm_reg   <= 1'b0;
            ss_reg    <= 1'b1;
        end else begin
            hs_d_reg  <= hs_d_next;
            vs_d_reg  <= vs_d_next;
            cnt_reg   <= cnt_next;
            per_reg   <= per_next;
            flg_reg   <= flg_next;
            rng_reg   <= rng_next;
            prot_reg  <= prot_next;
            cfg_reg   <= cfg_next;
            lines_reg <= lines_next;
            fok_reg   <= fok_next;
            ph_reg    <= ph_next;
            par_reg   <= par_next;
            pwm_reg   <= pwm_next;
            ss_reg    <= ss_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs; mode pins pass through their synchronisers
    // ----------------------------------------------------------------
    assign ext_clock_sel_o         = clk_sel;
    assign test_mode_o             = tst;
    assign double_rate_o           = rate;
    assign flags_o                 = flg_reg;
    assign pll_range_o             = rng_reg;
    assign protection_active_out_o = prot_reg;
    assign softstart_active_o      = ss_reg & ~ss_dis;
    assign switch_out_o            = cfg_reg.switch_ctrl_bit;
    assign dac_level_o             = cfg_reg.dac_level;
    assign pwm_o                   = pwm_reg;
    assign field_ok_o              = fok_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_PROT_STICKY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (hp || vp) |=> protection_active_out_o)
        else $error("protection output did not follow a trip");
    AST_PROT_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        protection_active_out_o |=> protection_active_out_o)
        else $error("protection output dropped without reset");
    AST_HIGH_IMPLIES_MID: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        flags_o.freq_flag_high |-> flags_o.freq_flag_mid)
        else $error("high flag without mid flag");
    AST_FLAG_MID: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (rate && per_reg <= dpc_pkg::CYC_35K) |=> flags_o.freq_flag_mid)
        else $error("mid flag missing at fast line rate");
    AST_SINGLE_RATE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !rate |=> (flags_o == '0))
        else $error("flags set in single line-rate range");
    AST_PLL_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (sup && mon && rate) |=> !(pll_range_o < $past(pll_range_o)))
        else $error("pll range lowered while supply still high");
    AST_SWITCH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        cfg_we_i |=> (switch_out_o == $past(cfg_i.switch_ctrl_bit)))
        else $error("switch output did not take written bit");
    AST_RESET: assert property (@(posedge core_clk_i)
        !rst_n_i |=> (!switch_out_o && !protection_active_out_o && flags_o == '0))
        else $error("outputs not cleared by reset");
    AST_SOFTSTART: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (ss_dis || !cfg_reg.softstart_en) |=> !ss_reg)
        else $error("softstart active while disabled");
endmodule

// ---- dpc_far_model.sv ----
// far-side model: line and field sync source plus supply watch
module dpc_far_model (
    // clock
    input  wire logic        core_clk_i,
    // commands from the bench
    input  wire logic [15:0] period_i,
    input  wire logic [9:0]  lines_i,
    input  wire logic        supply_high_i,
    // sync and supply lines
    output logic             hsync_o,
    output logic             vsync_o,
    output logic             supply_watch_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int hcnt = 0;
    int lcnt = 0;
    initial begin
        hsync_o = 1'b0;
        vsync_o = 1'b0;
        supply_watch_o = 1'b1;
    end
    // line sync is the timing reference; four-cycle pulses so the sampler cannot miss them
    always @(negedge core_clk_i) begin
        hcnt = (hcnt + 1 >= int'(period_i)) ? 0 : hcnt + 1;
        if (hcnt == 0) lcnt = (lcnt + 1 >= int'(lines_i)) ? 0 : lcnt + 1;
        hsync_o <= (hcnt < 4);
        vsync_o <= (lcnt == 0) && (hcnt < 4);
        supply_watch_o <= supply_high_i;
    end
endmodule

// ---- dpc_pin_ctrl_tb_top.sv ----
// testbench: pin control block driven by tasks and checked against expected values
module dpc_pin_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cks = 1'b0, tsel = 1'b0, lrs = 1'b0, mon = 1'b0, ss_dis = 1'b0;
    logic hprot = 1'b0, vprot = 1'b0, we = 1'b0, sup = 1'b1;
    logic [15:0] per = 16'd3200;
    logic [9:0] lines = 10'd200;
    dpc_pkg::dpc_cfg_s cfg = '0;
    logic hs, vs, sup_watch, ext, tm, dbl, prot, ss, switch_q, pwm, fok;
    logic [7:0] dac;
    dpc_pkg::dpc_flags_s flags;
    dpc_pkg::dpc_range_e rng;
    int err_total = 0;
    int checked = 0;
    int hi = 0;
    // row table: period, supply high, monitor, line rate, expected range code
    localparam int TP[6] = '{2600, 2800, 2800, 3200, 2600, 2600};
    localparam int TS[6] = '{1, 1, 0, 0, 1, 1};
    localparam int TM[6] = '{1, 1, 1, 1, 0, 0};
    localparam int TL[6] = '{1, 1, 1, 1, 1, 0};
    localparam int TR[6] = '{2, 2, 1, 0, 0, 0};
    // 100 MHz core clock
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    dpc_far_model u_far (.core_clk_i(core_clk_i), .period_i(per), .lines_i(lines),
        .supply_high_i(sup), .hsync_o(hs), .vsync_o(vs), .supply_watch_o(sup_watch));
    dpc_pin_ctrl u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .clock_source_select_i(cks), .test_select_i(tsel), .line_rate_select_i(lrs),
        .monitor_mode_i(mon), .hsync_i(hs), .vsync_i(vs), .supply_watch_in_i(sup_watch),
        .hprot_trip_i(hprot), .vprot_trip_i(vprot), .softstart_disable_in_i(ss_dis),
        .cfg_we_i(we), .cfg_i(cfg), .ext_clock_sel_o(ext), .test_mode_o(tm),
        .double_rate_o(dbl), .flags_o(flags), .pll_range_o(rng),
        .protection_active_out_o(prot), .softstart_active_o(ss), .switch_out_o(switch_q),
        .dac_level_o(dac), .pwm_o(pwm), .field_ok_o(fok));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    // one-cycle write strobe; outputs follow at the next edge
    task automatic wr(input logic s, input logic [7:0] d);
        cfg.switch_ctrl_bit = s;
        cfg.dac_level = d;
        we = 1'b1;
        cyc(1);
        we = 1'b0;
        cyc(1);   // idle cycle so a following call never re-raises the strobe in the same step
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog at 90k cycles, above the planned run of about 73k cycles
    initial begin
        #900000;
        err_total++;
        finish_test();
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        cyc(4);
        chk(16'({prot, switch_q, dac, flags}), 16'h0);
        chk(16'(rng), 16'(dpc_pkg::DPC_RANGE_31K));
        chk(16'(ss), 16'h1);
        rst_n_i = 1'b1;
        wr(1'b1, 8'hA5);
        chk(16'({switch_q, dac}), 16'h1A5);
        wr(1'b0, 8'h5A);
        chk(16'({switch_q, dac}), 16'h05A);
        cks = 1'b1;
        tsel = 1'b1;
        lrs = 1'b1;
        cyc(1);
        chk(16'({ext, tm, dbl}), 16'h0);
        cyc(1);
        chk(16'({ext, tm, dbl}), 16'h7);
        cks = 1'b0;
        tsel = 1'b0;
        hprot = 1'b1;
        cyc(1);
        hprot = 1'b0;
        cyc(1);
        chk(16'(prot), 16'h0);
        cyc(1);
        chk(16'(prot), 16'h1);
        cyc(5);
        chk(16'(prot), 16'h1);
        // second reset mid-run; the disable pin must mask the softstart held by reset
        rst_n_i = 1'b0;
        ss_dis = 1'b1;
        cyc(4);
        chk(16'({prot, switch_q, dac, ss}), 16'h0);
        rst_n_i = 1'b1;
        vprot = 1'b1;
        cyc(1);
        vprot = 1'b0;
        cyc(2);
        chk(16'({prot, ss}), 16'h2);
        ss_dis = 1'b0;
        // frequency flags and range follow the rows; the range waits for the supply
        for (int i = 0; i < 6; i++) begin
            per = 16'(TP[i]);
            sup = TS[i][0];
            mon = TM[i][0];
            lrs = TL[i][0];
            cyc(3 * TP[i] + 20);
            chk(16'(flags), TL[i] ? 16'({TP[i] <= 2857, TP[i] <= 2631}) : 16'h0);
            chk(16'(rng), 16'(TR[i]));
            chk(16'(dbl), 16'(TL[i]));
        end
        // lines per field at and outside the accepted span
        per = 16'd20;
        lines = 10'd192;
        cyc(3 * 20 * 192 + 50);
        chk(16'(fok), 16'h1);
        lines = 10'd191;
        cyc(3 * 20 * 192 + 50);
        chk(16'(fok), 16'h0);
        // constant-width pwm: 10 of every 20 cycles high on a 20-cycle line
        cfg.pwm_width = 8'h0A;
        wr(1'b0, 8'h5A);
        repeat (20) begin
            cyc(1);
            hi += int'(pwm);
        end
        chk(16'(hi), 16'h000A);
        finish_test();
    end
endmodule
